// File: core/flash_cmd_host.sv
// Notes on behaviour
// - operations start only from defined address/data write sequences, mostly two unlock writes first.
// - the host issues only valid values in the defined order.
// - after a wrong sequence the host writes F0 anywhere to return to array read.
// - single program is unlock, unlock, A0 at 555, then data at its location.
// - buffer load is unlock, unlock, 25, count, slot pairs; 29 confirms.
// - the written word count equals loaded locations minus one.
// - every buffer slot lies in the same write buffer page.
module flash_cmd_host (
  input logic clk_in,
  input logic rst_n_in,
  input logic cmd_valid_in,
  input flash_cmd_pkg::op_t cmd_op_in,
  input logic [flash_cmd_pkg::ADDR_W-1:0] cmd_addr_in,
  input logic [flash_cmd_pkg::DATA_W-1:0] cmd_data_in,
  input logic [flash_cmd_pkg::COUNT_W-1:0] cmd_count_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic refused_out,
  output logic bypass_out,
  output logic [flash_cmd_pkg::DATA_W-1:0] read_data_out,
  output logic [flash_cmd_pkg::ADDR_W-1:0] flash_addr_out,
  input logic [flash_cmd_pkg::DATA_W-1:0] flash_dq_in,
  output logic [flash_cmd_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out
);
  localparam int AW = flash_cmd_pkg::ADDR_W;
  localparam int DW = flash_cmd_pkg::DATA_W;
  localparam int PW = flash_cmd_pkg::PAGE_W;

  // =======================================================
  // sequence table: one bus write per step
  function automatic logic is_unlocked(input flash_cmd_pkg::op_t op);
    is_unlocked = op inside {flash_cmd_pkg::OP_PROGRAM, flash_cmd_pkg::OP_BUF_LOAD,
      flash_cmd_pkg::OP_ABORT_RESET, flash_cmd_pkg::OP_SECURE_ENTRY, flash_cmd_pkg::OP_SECURE_EXIT,
      flash_cmd_pkg::OP_IDENT_ENTRY, flash_cmd_pkg::OP_CHIP_ERASE, flash_cmd_pkg::OP_SECTOR_ERASE,
      flash_cmd_pkg::OP_BYP_ENTER};
  endfunction

  function automatic flash_cmd_pkg::step_t step_of(input flash_cmd_pkg::op_t op, input logic [2:0] idx);
    flash_cmd_pkg::step_t s;
    logic six;
    s = '{1'b1, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_USER, flash_cmd_pkg::CODE_RESET};
    six = (op == flash_cmd_pkg::OP_CHIP_ERASE) || (op == flash_cmd_pkg::OP_SECTOR_ERASE);
    if (is_unlocked(op) && (idx == 3'h0 || (six && idx == 3'h3))) begin
      s = '{1'b0, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::UNLOCK_CODE_1};
    end else if (is_unlocked(op) && (idx == 3'h1 || (six && idx == 3'h4))) begin
      s = '{1'b0, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_ALT, flash_cmd_pkg::UNLOCK_CODE_2};
    end else begin
      unique case (op)
        flash_cmd_pkg::OP_RESET: s.code = flash_cmd_pkg::CODE_RESET;
        flash_cmd_pkg::OP_PROGRAM: begin
          if (idx == 3'h2) s = '{1'b0, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_PROGRAM};
          else s.dsel = flash_cmd_pkg::DSEL_DATA;
        end
        flash_cmd_pkg::OP_BUF_LOAD: begin
          if (idx == 3'h2) s = '{1'b0, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_USER, flash_cmd_pkg::CODE_BUF_LOAD};
          else s.dsel = flash_cmd_pkg::DSEL_COUNT;
        end
        flash_cmd_pkg::OP_BUF_WORD: s.dsel = flash_cmd_pkg::DSEL_DATA;
        flash_cmd_pkg::OP_BUF_CONFIRM: s.code = flash_cmd_pkg::CODE_BUF_CONFIRM;
        flash_cmd_pkg::OP_ABORT_RESET: s = '{1'b1, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_RESET};
        flash_cmd_pkg::OP_SUSPEND: s.code = flash_cmd_pkg::CODE_SUSPEND;
        flash_cmd_pkg::OP_RESUME: s.code = flash_cmd_pkg::CODE_RESUME;
        flash_cmd_pkg::OP_SECURE_ENTRY: s = '{1'b1, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_SECURE_ENTRY};
        flash_cmd_pkg::OP_SECURE_EXIT: begin
          if (idx == 3'h2) s = '{1'b0, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_IDENT};
          else s.code = flash_cmd_pkg::CODE_EXIT;
        end
        flash_cmd_pkg::OP_IDENT_ENTRY: s = '{1'b1, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_IDENT};
        flash_cmd_pkg::OP_CHIP_ERASE, flash_cmd_pkg::OP_SECTOR_ERASE: begin
          if (idx == 3'h2) s = '{1'b0, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_ERASE};
          else if (op == flash_cmd_pkg::OP_CHIP_ERASE) s = '{1'b1, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_CHIP};
          else s.code = flash_cmd_pkg::CODE_SECTOR;
        end
        flash_cmd_pkg::OP_BYP_ENTER: s = '{1'b1, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_CMD, flash_cmd_pkg::CODE_BYPASS};
        flash_cmd_pkg::OP_BYP_PROGRAM: begin
          if (idx == 3'h0) s = '{1'b0, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_USER, flash_cmd_pkg::CODE_PROGRAM};
          else s.dsel = flash_cmd_pkg::DSEL_DATA;
        end
        flash_cmd_pkg::OP_BYP_SECTOR_ERASE, flash_cmd_pkg::OP_BYP_CHIP_ERASE: begin
          s.last = (idx != 3'h0);
          if (idx == 3'h0) s.code = flash_cmd_pkg::CODE_ERASE;
          else if (op == flash_cmd_pkg::OP_BYP_CHIP_ERASE) s.code = flash_cmd_pkg::CODE_CHIP;
          else s.code = flash_cmd_pkg::CODE_SECTOR;
        end
        flash_cmd_pkg::OP_BYP_RESET: begin
          s.last = (idx != 3'h0);
          s.code = (idx == 3'h0) ? flash_cmd_pkg::CODE_IDENT : flash_cmd_pkg::CODE_EXIT;
        end
        flash_cmd_pkg::OP_QUERY: s = '{1'b1, flash_cmd_pkg::DSEL_CODE, flash_cmd_pkg::ASEL_QUERY, flash_cmd_pkg::CODE_QUERY};
        default: s.code = flash_cmd_pkg::CODE_RESET;
      endcase
    end
    step_of = s;
  endfunction

  // =======================================================
  // data pin synchroniser
  logic [DW-1:0] dq_s1, dq_s2, dq_s3;
  logic [DW-1:0] next_dq_s1, next_dq_s2, next_dq_s3;

  always_comb begin
    next_dq_s1 = flash_dq_in;
    next_dq_s2 = dq_s1;
    next_dq_s3 = dq_s2;
  end

  always_ff @(posedge clk_in) begin
    dq_s1 <= next_dq_s1;
    dq_s2 <= next_dq_s2;
    dq_s3 <= next_dq_s3;
  end

  // =======================================================
  // sequencer
  flash_cmd_pkg::state_t state, next_state;
  flash_cmd_pkg::op_t op, next_op;
  logic [2:0] idx, next_idx;
  logic [flash_cmd_pkg::TIMER_W-1:0] timer, next_timer;
  logic [AW-1:0] addr, next_addr;
  logic [DW-1:0] data, next_data;
  logic [flash_cmd_pkg::COUNT_W-1:0] buf_left, next_buf_left, word_count, next_word_count;
  logic [AW-PW-1:0] buf_page, next_buf_page;
  logic buf_open, next_buf_open, buf_first, next_buf_first, bypass, next_bypass;
  logic next_ready, next_done, next_refused, next_dq_oe_n, next_ce_n, next_we_n, next_oe_n;
  logic [DW-1:0] next_read_data, next_dq;
  logic [AW-1:0] next_flash_addr;
  flash_cmd_pkg::step_t st;
  logic take, refuse, byp_op;

  always_comb begin
    st = step_of(op, idx);
    take = cmd_valid_in && cmd_ready_out;
    byp_op = cmd_op_in inside {flash_cmd_pkg::OP_BYP_PROGRAM, flash_cmd_pkg::OP_BYP_SECTOR_ERASE,
      flash_cmd_pkg::OP_BYP_CHIP_ERASE, flash_cmd_pkg::OP_BYP_RESET};
    refuse = (byp_op && !bypass)
      || (cmd_op_in == flash_cmd_pkg::OP_BUF_WORD && (!buf_open || buf_left == '0
          || (!buf_first && cmd_addr_in[AW-1:PW] != buf_page)))
      || (cmd_op_in == flash_cmd_pkg::OP_BUF_CONFIRM && !(buf_open && buf_left == '0))
      || (cmd_op_in == flash_cmd_pkg::OP_BUF_LOAD
          && (cmd_count_in == '0 || cmd_count_in > flash_cmd_pkg::BUF_WORDS));
    next_state = state;
    next_op = op;
    next_idx = idx;
    next_timer = timer;
    next_addr = addr;
    next_data = data;
    next_buf_left = buf_left;
    next_word_count = word_count;
    next_buf_page = buf_page;
    next_buf_open = buf_open;
    next_buf_first = buf_first;
    next_bypass = bypass;
    next_ready = cmd_ready_out;
    next_done = 1'b0;
    next_refused = 1'b0;
    next_read_data = read_data_out;
    next_flash_addr = flash_addr_out;
    next_dq = flash_dq_out;
    next_dq_oe_n = flash_dq_oe_n_out;
    next_ce_n = flash_ce_n_out;
    next_we_n = flash_we_n_out;
    next_oe_n = flash_oe_n_out;
    unique case (state)
      flash_cmd_pkg::ST_IDLE: begin
        if (take && refuse) begin
          next_refused = 1'b1;
        end else if (take) begin
          next_ready = 1'b0;
          next_op = cmd_op_in;
          next_idx = 3'h0;
          next_addr = cmd_addr_in;
          next_data = cmd_data_in;
          unique case (cmd_op_in)
            flash_cmd_pkg::OP_BUF_LOAD: begin
              next_buf_open = 1'b1;
              next_buf_first = 1'b1;
              next_buf_left = cmd_count_in;
              next_word_count = cmd_count_in - 6'h01;
            end
            flash_cmd_pkg::OP_BUF_WORD: begin
              next_buf_left = buf_left - 6'h01;
              next_buf_first = 1'b0;
              next_buf_page = cmd_addr_in[AW-1:PW];
            end
            flash_cmd_pkg::OP_BUF_CONFIRM, flash_cmd_pkg::OP_RESET, flash_cmd_pkg::OP_ABORT_RESET: begin
              next_buf_open = 1'b0;
            end
            flash_cmd_pkg::OP_BYP_ENTER: next_bypass = 1'b1;
            flash_cmd_pkg::OP_BYP_RESET: next_bypass = 1'b0;
            default: next_buf_open = buf_open;
          endcase
          if (cmd_op_in == flash_cmd_pkg::OP_READ) begin
            next_flash_addr = cmd_addr_in;
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
            next_timer = flash_cmd_pkg::TIMER_W'(flash_cmd_pkg::READ_WAIT_CYC - 1);
            next_state = flash_cmd_pkg::ST_READ;
          end else begin
            next_state = flash_cmd_pkg::ST_PRESENT;
          end
        end
      end
      flash_cmd_pkg::ST_PRESENT: begin
        unique case (st.asel)
          flash_cmd_pkg::ASEL_CMD: next_flash_addr = flash_cmd_pkg::CMD_ADDR;
          flash_cmd_pkg::ASEL_ALT: next_flash_addr = flash_cmd_pkg::ALT_ADDR;
          flash_cmd_pkg::ASEL_QUERY: next_flash_addr = flash_cmd_pkg::QUERY_ADDR;
          flash_cmd_pkg::ASEL_USER: next_flash_addr = addr;
        endcase
        unique case (st.dsel)
          flash_cmd_pkg::DSEL_DATA: next_dq = data;
          flash_cmd_pkg::DSEL_COUNT: next_dq = {{(DW - flash_cmd_pkg::COUNT_W){1'b0}}, word_count};
          default: next_dq = {flash_cmd_pkg::UPPER_FILL, st.code};
        endcase
        next_dq_oe_n = 1'b0;
        next_ce_n = 1'b0;
        next_state = flash_cmd_pkg::ST_SETUP;
      end
      flash_cmd_pkg::ST_SETUP: begin
        next_we_n = 1'b0;
        next_timer = flash_cmd_pkg::TIMER_W'(flash_cmd_pkg::WE_LOW_CYC - 1);
        next_state = flash_cmd_pkg::ST_WE_LOW;
      end
      flash_cmd_pkg::ST_WE_LOW: begin
        next_timer = timer - 4'h1;
        if (timer == '0) begin
          next_we_n = 1'b1;
          next_timer = flash_cmd_pkg::TIMER_W'(flash_cmd_pkg::WE_HIGH_CYC - 1);
          next_state = flash_cmd_pkg::ST_WE_HIGH;
        end
      end
      flash_cmd_pkg::ST_WE_HIGH: begin
        next_timer = timer - 4'h1;
        if (timer == '0 && st.last) begin
          next_ce_n = 1'b1;
          next_dq_oe_n = 1'b1;
          next_done = 1'b1;
          next_ready = 1'b1;
          next_state = flash_cmd_pkg::ST_IDLE;
        end else if (timer == '0) begin
          next_idx = idx + 3'h1;
          next_state = flash_cmd_pkg::ST_PRESENT;
        end
      end
      flash_cmd_pkg::ST_READ: begin
        if (timer != '0) begin
          next_timer = timer - 4'h1;
        end else if (dq_s2 == dq_s3) begin
          next_read_data = dq_s3;
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_done = 1'b1;
          next_ready = 1'b1;
          next_state = flash_cmd_pkg::ST_IDLE;
        end
      end
      default: next_state = flash_cmd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= flash_cmd_pkg::ST_IDLE;
      op <= flash_cmd_pkg::OP_READ;
      idx <= 3'h0;
      timer <= '0;
      addr <= '0;
      data <= '0;
      buf_left <= '0;
      word_count <= '0;
      buf_page <= '0;
      buf_open <= 1'b0;
      buf_first <= 1'b0;
      bypass <= 1'b0;
      cmd_ready_out <= 1'b1;
      done_out <= 1'b0;
      refused_out <= 1'b0;
      bypass_out <= 1'b0;
      read_data_out <= '0;
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_n_out <= 1'b1;
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      idx <= next_idx;
      timer <= next_timer;
      addr <= next_addr;
      data <= next_data;
      buf_left <= next_buf_left;
      word_count <= next_word_count;
      buf_page <= next_buf_page;
      buf_open <= next_buf_open;
      buf_first <= next_buf_first;
      bypass <= next_bypass;
      cmd_ready_out <= next_ready;
      done_out <= next_done;
      refused_out <= next_refused;
      bypass_out <= next_bypass;
      read_data_out <= next_read_data;
      flash_addr_out <= next_flash_addr;
      flash_dq_out <= next_dq;
      flash_dq_oe_n_out <= next_dq_oe_n;
      flash_ce_n_out <= next_ce_n;
      flash_we_n_out <= next_we_n;
      flash_oe_n_out <= next_oe_n;
    end
  end

  // =======================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_we_low_width: assert property ($fell(flash_we_n_out) |-> !flash_we_n_out [*4] ##1 flash_we_n_out)
    else $error("write strobe low time wrong");
  a_we_high_gap: assert property ($rose(flash_we_n_out) && !flash_ce_n_out |-> flash_we_n_out [*7])
    else $error("write strobes too close");
  a_no_bus_fight: assert property (!flash_we_n_out |-> flash_oe_n_out && !flash_dq_oe_n_out && !flash_ce_n_out)
    else $error("write cycle with bad control levels");
  a_unlock_first: assert property ($fell(flash_we_n_out) && idx == 3'h0 && is_unlocked(op)
    |-> flash_addr_out == flash_cmd_pkg::CMD_ADDR && flash_dq_out[7:0] == flash_cmd_pkg::UNLOCK_CODE_1)
    else $error("first unlock write wrong");
  a_reset_code: assert property ($fell(flash_we_n_out) && op == flash_cmd_pkg::OP_RESET
    |-> flash_dq_out[7:0] == flash_cmd_pkg::CODE_RESET && st.last)
    else $error("reset write wrong");
  a_program_fourth: assert property ($fell(flash_we_n_out) && op == flash_cmd_pkg::OP_PROGRAM && idx == 3'h3
    |-> flash_dq_out == data && flash_addr_out == addr && $past(idx, 8) == 3'h2)
    else $error("program data write wrong");
  a_buffer_count: assert property ($fell(flash_we_n_out) && op == flash_cmd_pkg::OP_BUF_LOAD && idx == 3'h3
    |-> flash_dq_out[5:0] == buf_left - 6'h01)
    else $error("word count not locations minus one");
  a_buffer_page: assert property ($fell(flash_we_n_out) && op == flash_cmd_pkg::OP_BUF_WORD
    |-> flash_addr_out[AW-1:PW] == buf_page)
    else $error("buffer slot outside page");
  a_confirm_full: assert property ($fell(flash_we_n_out) && op == flash_cmd_pkg::OP_BUF_CONFIRM
    |-> buf_left == '0 && flash_dq_out[7:0] == flash_cmd_pkg::CODE_BUF_CONFIRM)
    else $error("confirm before buffer filled");
  a_read_cycle: assert property ($fell(flash_oe_n_out) |-> !flash_oe_n_out [*8] ##[3:40] (flash_oe_n_out && done_out))
    else $error("read cycle timing wrong");
endmodule

// File: core/flash_cmd_pkg.sv
package flash_cmd_pkg;
  // =======================================================
  // widths
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int PAGE_W = 5;
  localparam int COUNT_W = 6;
  localparam int TIMER_W = 4;
  localparam logic [COUNT_W-1:0] BUF_WORDS = 6'h20;

  // =======================================================
  // fixed bus addresses and codes
  localparam logic [ADDR_W-1:0] CMD_ADDR = 26'h0000555;
  localparam logic [ADDR_W-1:0] ALT_ADDR = 26'h00002AA;
  localparam logic [ADDR_W-1:0] QUERY_ADDR = 26'h0000055;
  localparam logic [7:0] UPPER_FILL = 8'h00;
  localparam logic [7:0] UNLOCK_CODE_1 = 8'hAA;
  localparam logic [7:0] UNLOCK_CODE_2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_BUF_LOAD = 8'h25;
  localparam logic [7:0] CODE_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_SECURE_ENTRY = 8'h88;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_EXIT = 8'h00;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECTOR = 8'h30;
  localparam logic [7:0] CODE_BYPASS = 8'h20;
  localparam logic [7:0] CODE_QUERY = 8'h98;

  // =======================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WE_LOW_NS = 35;
  localparam int WE_HIGH_NS = 30;
  localparam int WRITE_CYCLE_NS = 90;
  localparam int READ_ACCESS_NS = 110;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_MIN = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_CYC = (WE_CYCLE_CYC - WE_LOW_CYC > WE_HIGH_MIN) ? WE_CYCLE_CYC - WE_LOW_CYC : WE_HIGH_MIN;
  localparam int READ_WAIT_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =======================================================
  // types
  typedef enum logic [4:0] {
    OP_READ, OP_RESET, OP_PROGRAM, OP_BUF_LOAD, OP_BUF_WORD, OP_BUF_CONFIRM, OP_ABORT_RESET,
    OP_SUSPEND, OP_RESUME, OP_SECURE_ENTRY, OP_SECURE_EXIT, OP_IDENT_ENTRY, OP_CHIP_ERASE,
    OP_SECTOR_ERASE, OP_BYP_ENTER, OP_BYP_PROGRAM, OP_BYP_SECTOR_ERASE, OP_BYP_CHIP_ERASE,
    OP_BYP_RESET, OP_QUERY
  } op_t;
  typedef enum logic [1:0] {ASEL_CMD, ASEL_ALT, ASEL_QUERY, ASEL_USER} asel_t;
  typedef enum logic [1:0] {DSEL_CODE, DSEL_DATA, DSEL_COUNT} dsel_t;
  typedef struct packed {
    logic last;
    dsel_t dsel;
    asel_t asel;
    logic [7:0] code;
  } step_t;
  typedef enum logic [2:0] {ST_IDLE, ST_PRESENT, ST_SETUP, ST_WE_LOW, ST_WE_HIGH, ST_READ} state_t;
endpackage

// File: sim/flash_command_sequence_decoder_tb_top.sv
module flash_command_sequence_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
  localparam logic [15:0] PART = 16'h1234; // arbitrary value
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  flash_cmd_pkg::op_t cmd_op_in = flash_cmd_pkg::OP_READ;
  logic [25:0] cmd_addr_in = 26'h0;
  logic [15:0] cmd_data_in = 16'h0;
  logic [5:0] cmd_count_in = 6'h0;
  logic cmd_ready_out, done_out, refused_out, bypass_out, dq_oe_n, ce_n, we_n, oe_n;
  logic [15:0] read_data_out, dq_host, dq_mdl, dq_wire;
  logic [25:0] flash_addr_out;
  int miscompares = 0;
  int n_compared = 0;
  int p = 0;
  always #5 clk_in = ~clk_in;
  assign dq_wire = dq_oe_n ? dq_mdl : dq_host;
  flash_cmd_host dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .cmd_count_in(cmd_count_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out), .refused_out(refused_out), .bypass_out(bypass_out), .read_data_out(read_data_out),
    .flash_addr_out(flash_addr_out), .flash_dq_in(dq_wire), .flash_dq_out(dq_host), .flash_dq_oe_n_out(dq_oe_n),
    .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n));
  flash_device_model #(.MAKER_ID(MAKER), .PART_ID(PART)) mdl (.addr_in(flash_addr_out), .dq_in(dq_wire),
    .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .dq_out(dq_mdl));
  // =======================================================
  // shared tasks
  task automatic chk(input string nm, input logic [41:0] seen, input logic [41:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input flash_cmd_pkg::op_t o, input logic [25:0] a, input logic [15:0] d, input logic [5:0] c,
                    input logic ref_exp);
    int t;
    t = 0;
    cmd_op_in <= o;
    cmd_addr_in <= a;
    cmd_data_in <= d;
    cmd_count_in <= c;
    cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    do begin
      @(negedge clk_in);
      t++;
    end while (done_out !== 1'b1 && refused_out !== 1'b1 && t < 400);
    chk("answer", 42'(t < 400), 42'd1);
    chk("refused", 42'(refused_out), 42'(ref_exp));
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [25:0] a, input logic [15:0] d);
    chk("bus write", {mdl.log_a[p[6:0]], mdl.log_d[p[6:0]]}, {a, d});
    p++;
  endtask
  task automatic ul;
    wr(26'h555, 16'h00AA);
    wr(26'h2AA, 16'h0055);
  endtask
  task automatic fin;
    chk("write count", 42'(mdl.n_wr), 42'(p));
  endtask
  task automatic rd(input logic [25:0] a, input logic [15:0] e);
    op(flash_cmd_pkg::OP_READ, a, 16'h0, 6'h0, 1'b0);
    chk("read data", 42'(read_data_out), 42'(e));
  endtask
  // =======================================================
  // scenarios
  task automatic t_reset;
    chk("idle pins", 42'({cmd_ready_out, ce_n, we_n, oe_n, dq_oe_n, done_out, bypass_out}), 42'h7C);
    rd(26'h0123456, 16'h3456 ^ 16'h5A5A);
    fin;
  endtask
  task automatic t_program;
    op(flash_cmd_pkg::OP_PROGRAM, 26'h1234567, 16'hBEEF, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h00A0);
    wr(26'h1234567, 16'hBEEF);
    fin;
  endtask
  task automatic t_buffer;
    op(flash_cmd_pkg::OP_BUF_LOAD, 26'h0040020, 16'h0, 6'h0, 1'b1);
    op(flash_cmd_pkg::OP_BUF_LOAD, 26'h0040020, 16'h0, 6'h2, 1'b0);
    ul;
    wr(26'h0040020, 16'h0025);
    wr(26'h0040020, 16'h0001);
    op(flash_cmd_pkg::OP_BUF_WORD, 26'h0040021, 16'h1111, 6'h0, 1'b0);
    wr(26'h0040021, 16'h1111);
    op(flash_cmd_pkg::OP_BUF_WORD, 26'h0040060, 16'h2222, 6'h0, 1'b1);
    op(flash_cmd_pkg::OP_BUF_CONFIRM, 26'h0040020, 16'h0, 6'h0, 1'b1);
    op(flash_cmd_pkg::OP_BUF_WORD, 26'h004003F, 16'h3333, 6'h0, 1'b0);
    wr(26'h004003F, 16'h3333);
    op(flash_cmd_pkg::OP_BUF_WORD, 26'h0040022, 16'h4444, 6'h0, 1'b1);
    op(flash_cmd_pkg::OP_BUF_CONFIRM, 26'h0040020, 16'h0, 6'h0, 1'b0);
    wr(26'h0040020, 16'h0029);
    fin;
  endtask
  task automatic t_modes;
    op(flash_cmd_pkg::OP_SUSPEND, 26'h0000100, 16'h0, 6'h0, 1'b0);
    wr(26'h0000100, 16'h00B0);
    chk("suspend idle", 42'(mdl.susp), 42'd0);
    op(flash_cmd_pkg::OP_RESUME, 26'h0000100, 16'h0, 6'h0, 1'b0);
    wr(26'h0000100, 16'h0030);
    op(flash_cmd_pkg::OP_IDENT_ENTRY, 26'h0, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h0090);
    rd(26'h0040002, 16'h0001);
    rd(26'h0000003, 16'h0080);
    rd(26'h0000000, MAKER);
    rd(26'h0000001, PART);
    op(flash_cmd_pkg::OP_RESET, 26'h0000777, 16'h0, 6'h0, 1'b0);
    wr(26'h0000777, 16'h00F0);
    rd(26'h0000777, 16'h0777 ^ 16'h5A5A);
    op(flash_cmd_pkg::OP_SECURE_ENTRY, 26'h0, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h0088);
    rd(26'h0000010, 16'h0010 ^ 16'hC3C3);
    op(flash_cmd_pkg::OP_SECURE_EXIT, 26'h0000999, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h0090);
    wr(26'h0000999, 16'h0000);
    rd(26'h0000010, 16'h0010 ^ 16'h5A5A);
    fin;
  endtask
  task automatic t_erase_bypass;
    op(flash_cmd_pkg::OP_SECTOR_ERASE, 26'h0080000, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h0080);
    ul;
    wr(26'h0080000, 16'h0030);
    op(flash_cmd_pkg::OP_SUSPEND, 26'h0080000, 16'h0, 6'h0, 1'b0);
    wr(26'h0080000, 16'h00B0);
    chk("suspend erase", 42'(mdl.susp), 42'd1);
    op(flash_cmd_pkg::OP_BYP_PROGRAM, 26'h0080004, 16'hCAFE, 6'h0, 1'b1);
    op(flash_cmd_pkg::OP_BYP_ENTER, 26'h0, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h0020);
    chk("bypass", 42'(bypass_out), 42'd1);
    op(flash_cmd_pkg::OP_BYP_PROGRAM, 26'h0080004, 16'hCAFE, 6'h0, 1'b0);
    wr(26'h0080004, 16'h00A0);
    wr(26'h0080004, 16'hCAFE);
    op(flash_cmd_pkg::OP_BYP_RESET, 26'h0000004, 16'h0, 6'h0, 1'b0);
    wr(26'h0000004, 16'h0090);
    wr(26'h0000004, 16'h0000);
    chk("bypass", 42'(bypass_out), 42'd0);
    op(flash_cmd_pkg::OP_QUERY, 26'h0, 16'h0, 6'h0, 1'b0);
    wr(26'h0000055, 16'h0098);
    fin;
  endtask
  task automatic t_rest;
    op(flash_cmd_pkg::OP_BUF_LOAD, 26'h0040020, 16'h0, 6'h21, 1'b1);
    op(flash_cmd_pkg::OP_BUF_LOAD, 26'h0040020, 16'h0, 6'h20, 1'b0);
    ul;
    wr(26'h0040020, 16'h0025);
    wr(26'h0040020, 16'h001F);
    op(flash_cmd_pkg::OP_ABORT_RESET, 26'h0, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h00F0);
    op(flash_cmd_pkg::OP_BUF_WORD, 26'h0040021, 16'h5555, 6'h0, 1'b1);
    op(flash_cmd_pkg::OP_CHIP_ERASE, 26'h0, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h0080);
    ul;
    wr(26'h555, 16'h0010);
    op(flash_cmd_pkg::OP_BYP_ENTER, 26'h0, 16'h0, 6'h0, 1'b0);
    ul;
    wr(26'h555, 16'h0020);
    op(flash_cmd_pkg::OP_BYP_SECTOR_ERASE, 26'h00C0000, 16'h0, 6'h0, 1'b0);
    wr(26'h00C0000, 16'h0080);
    wr(26'h00C0000, 16'h0030);
    op(flash_cmd_pkg::OP_BYP_CHIP_ERASE, 26'h0000008, 16'h0, 6'h0, 1'b0);
    wr(26'h0000008, 16'h0080);
    wr(26'h0000008, 16'h0010);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("reset pins", 42'({cmd_ready_out, ce_n, we_n, oe_n, dq_oe_n, done_out, bypass_out}), 42'h7C);
    op(flash_cmd_pkg::OP_BYP_RESET, 26'h0000008, 16'h0, 6'h0, 1'b1);
    fin;
  endtask
  task automatic test_done;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_program;
    t_buffer;
    t_modes;
    t_erase_bypass;
    t_rest;
    test_done;
  end
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
endmodule

// File: sim/flash_device_model.sv
module flash_device_model #(
  parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h1234 // arbitrary value
) (
  input wire logic [25:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  output logic [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [25:0] log_a [0:127];
  logic [15:0] log_d [0:127];
  int n_wr = 0;
  logic [25:0] a_lat = 26'h0;
  logic [25:0] a1 = 26'h0;
  logic [25:0] a2 = 26'h0;
  logic [7:0] d1 = 8'h00;
  logic [7:0] d2 = 8'h00;
  logic [1:0] mode = 2'h0;
  logic armed = 1'b0;
  logic susp = 1'b0;
  logic ers = 1'b0;
  logic unl = 1'b0;
  logic [15:0] rd;
  logic [15:0] last_q = 16'h0000;
  // =======================================================
  // write cycles
  always @(negedge we_n_in or negedge ce_n_in) begin
    if (!we_n_in && !ce_n_in) a_lat = addr_in;
  end
  always @(posedge we_n_in or posedge ce_n_in) begin
    if (we_n_in ^ ce_n_in) begin
      log_a[n_wr[6:0]] = a_lat;
      log_d[n_wr[6:0]] = dq_in;
      n_wr++;
      unl = a2 == 26'h555 && d2 == 8'hAA && a1 == 26'h2AA && d1 == 8'h55 && a_lat == 26'h555;
      if (dq_in[7:0] == 8'hF0) mode = 2'h0;
      else if (unl && dq_in[7:0] == 8'h88) mode = 2'h2;
      else if (unl && dq_in[7:0] == 8'h90) mode = 2'h1;
      else if (armed && dq_in[7:0] == 8'h00) mode = 2'h0;
      if (dq_in[7:0] == 8'h30 && !susp) ers = (d1 == 8'h55) || (d1 == 8'h80);
      if (dq_in[7:0] == 8'hB0 && ers) susp = 1'b1;
      if (dq_in[7:0] == 8'h30) susp = 1'b0;
      armed = unl && dq_in[7:0] == 8'h90;
      a2 = a1;
      d2 = d1;
      a1 = a_lat;
      d1 = dq_in[7:0];
    end
  end
  // =======================================================
  // read path
  always_comb begin
    rd = addr_in[15:0] ^ 16'h5A5A;
    if (mode == 2'h2) rd = addr_in[15:0] ^ 16'hC3C3;
    if (mode == 2'h1) begin
      case (addr_in[7:0])
        8'h00: rd = MAKER_ID;
        8'h01: rd = PART_ID;
        8'h02: rd = 16'h0001;
        8'h03: rd = 16'h0080;
        default: rd = 16'h0000;
      endcase
    end
  end
  always @(ce_n_in, oe_n_in, rd) begin
    if (!ce_n_in && !oe_n_in) last_q = rd;
  end
  // released pins show the inverse of the last word so a stale capture cannot pass
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~last_q;
endmodule
